// >>> rtl/dtx_pkg.sv
// package: opcode classes, pointer selects and cycle counts for the transfer executor
package dtx_pkg;
    typedef enum logic [4:0] {
        DTX_OP_NOP,
        DTX_OP_COPY_REGISTER,
        DTX_OP_COPY_REGISTER_PAIR,
        DTX_OP_LOAD_IMMEDIATE,
        DTX_OP_IO_IN,
        DTX_OP_IO_OUT,
        DTX_OP_READ_VIA_POINTER,
        DTX_OP_READ_POINTER_OFFSET,
        DTX_OP_READ_ABSOLUTE_ADDRESS,
        DTX_OP_WRITE_VIA_POINTER,
        DTX_OP_WRITE_POINTER_OFFSET,
        DTX_OP_WRITE_ABSOLUTE_ADDRESS,
        DTX_OP_READ_PROGRAM_MEMORY,
        DTX_OP_PUSH,
        DTX_OP_POP,
        DTX_OP_SLEEP,
        DTX_OP_WATCHDOG_RESTART,
        DTX_OP_BREAK
    } dtx_op_t;

    typedef enum logic [1:0] {
        DTX_PTR_X,
        DTX_PTR_Y,
        DTX_PTR_Z
    } dtx_ptr_t;

    typedef enum logic [1:0] {
        DTX_ADJ_NONE,
        DTX_ADJ_POST_INC,
        DTX_ADJ_PRE_DEC
    } dtx_adj_t;

    localparam int DTX_ADDR_W = 16;
    localparam logic [4:0] DTX_R0 = 5'h00;
    localparam logic [15:0] DTX_ONE16 = 16'h0001;
    localparam logic [15:0] DTX_SP_RESET = 16'h01ff;
    localparam logic [1:0] DTX_CYC_ONE = 2'h1;
    localparam logic [1:0] DTX_CYC_TWO = 2'h2;
    localparam logic [1:0] DTX_CYC_THREE = 2'h3;
endpackage : dtx_pkg

// >>> rtl/dtx_ptr_unit.sv
// pointer update unit, shared by the load and store forms; the stack pointer is updated in the executor
`timescale 1ns/1ps
`default_nettype none
module dtx_ptr_unit (
    input wire logic [15:0] base,
    input wire dtx_pkg::dtx_adj_t adj,
    input wire logic [5:0] disp,
    output logic [15:0] eff_addr,
    output logic [15:0] new_ptr
);
    always_comb begin
        case (adj)
            dtx_pkg::DTX_ADJ_POST_INC: begin
                eff_addr = base;
                new_ptr = base + dtx_pkg::DTX_ONE16;
            end
            dtx_pkg::DTX_ADJ_PRE_DEC: begin
                eff_addr = base - dtx_pkg::DTX_ONE16;
                new_ptr = base - dtx_pkg::DTX_ONE16;
            end
            default: begin
                eff_addr = base + {10'h000, disp};
                new_ptr = base;
            end
        endcase
    end
endmodule : dtx_ptr_unit
`default_nettype wire

// >>> rtl/dtx_exec.sv
// executor for data-transfer and core-control instructions
// Summary of operation
// RULE1 - pointer load, optional post-increment, two cycles
// RULE2 - pre-decrement pointer, then load, two cycles
// RULE3 - load at Y/Z plus q, pointer kept
// RULE4 - load from absolute address k, two cycles
// RULE5 - pointer store, optional post-increment, two cycles
// RULE6 - pre-decrement pointer, then store, two cycles
// RULE7 - store at Y/Z plus q, pointer kept
// RULE8 - store to absolute address k, two cycles
// RULE9 - program read via Z, default R0, three cycles
// RULE10 - push register onto stack, two cycles
// RULE11 - pop stack into register, two cycles
// RULE12 - sleep takes one cycle, enters selected mode when sleep_enable is set
// RULE13 - watchdog restart in one cycle
// RULE14 - break only signals debug, no timing
// RULE15 - simple moves one cycle, flags never change
`timescale 1ns/1ps
`default_nettype none
module dtx_exec (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic issue,
    input wire dtx_pkg::dtx_op_t op,
    input wire dtx_pkg::dtx_ptr_t ptr_sel,
    input wire dtx_pkg::dtx_adj_t adj,
    input wire logic [4:0] rd,
    input wire logic [7:0] rr_val,
    input wire logic [7:0] rr_hi_val,
    input wire logic [7:0] imm8,
    input wire logic [5:0] disp,
    input wire logic [15:0] abs_addr,
    input wire logic use_r0,
    input wire logic [15:0] ptr_x,
    input wire logic [15:0] ptr_y,
    input wire logic [15:0] ptr_z,
    input wire logic [7:0] dmem_rdata,
    input wire logic [7:0] pmem_rdata,
    input wire logic [7:0] io_rdata,
    input wire logic [2:0] sleep_mode,
    input wire logic sleep_enable,
    output logic busy,
    output logic done,
    output logic dmem_re,
    output logic dmem_we,
    output logic [15:0] dmem_addr,
    output logic [7:0] dmem_wdata,
    output logic pmem_re,
    output logic [15:0] pmem_addr,
    output logic io_re,
    output logic io_we,
    output logic [7:0] io_wdata,
    output logic rf_we,
    output logic rf_we_pair,
    output logic [4:0] rf_waddr,
    output logic [7:0] rf_wdata,
    output logic [7:0] rf_wdata_hi,
    output logic ptr_we,
    output dtx_pkg::dtx_ptr_t ptr_wsel,
    output logic [15:0] ptr_wdata,
    output logic [15:0] sp,
    output logic flags_we,
    output logic sleep_req,
    output logic [2:0] sleep_mode_out,
    output logic wdt_restart,
    output logic debug_break
);
    typedef enum logic [1:0] {DTX_IDLE, DTX_EXEC, DTX_FINISH} dtx_state_t;

    dtx_state_t st_q, st_d;
    logic [15:0] base_q, base_d;
    dtx_pkg::dtx_adj_t adj_q, adj_d;
    dtx_pkg::dtx_op_t op_q, op_d;
    logic [4:0] rd_q, rd_d;
    logic [15:0] sp_q, sp_d;
    logic [15:0] base, eff, newp;
    logic busy_q, busy_d, done_q, done_d;
    logic dre_q, dre_d, dwe_q, dwe_d, pre_q, pre_d, iore_q, iore_d, iowe_q, iowe_d;
    logic [15:0] daddr_q, daddr_d, paddr_q, paddr_d;
    logic [7:0] dwd_q, dwd_d, iowd_q, iowd_d;
    logic rfwe_q, rfwe_d, rfpair_q, rfpair_d;
    logic [4:0] rfwa_q, rfwa_d;
    logic [7:0] rfwd_q, rfwd_d, rfwdh_q, rfwdh_d;
    logic pwe_q, pwe_d;
    dtx_pkg::dtx_ptr_t pws_q, pws_d;
    logic [15:0] pwd_q, pwd_d;
    logic slp_q, slp_d, wdt_q, wdt_d, brk_q, brk_d;
    logic [2:0] slpm_q, slpm_d;

    function automatic logic [15:0] sel_ptr(input dtx_pkg::dtx_ptr_t s, input logic [15:0] x,
                                            input logic [15:0] y, input logic [15:0] z);
        case (s)
            dtx_pkg::DTX_PTR_X: sel_ptr = x;
            dtx_pkg::DTX_PTR_Y: sel_ptr = y;
            default: sel_ptr = z;
        endcase
    endfunction : sel_ptr

    assign base = sel_ptr(ptr_sel, ptr_x, ptr_y, ptr_z);

    dtx_ptr_unit u_ptr (
        .base(base),
        .adj(adj),
        .disp((op == dtx_pkg::DTX_OP_READ_POINTER_OFFSET ||
               op == dtx_pkg::DTX_OP_WRITE_POINTER_OFFSET) ? disp : 6'h00),
        .eff_addr(eff),
        .new_ptr(newp)
    );

    always_comb begin
        st_d = st_q;
        base_d = base_q;
        adj_d = adj_q;
        op_d = op_q;
        rd_d = rd_q;
        sp_d = sp_q;
        busy_d = busy_q;
        done_d = 1'b0;
        dre_d = 1'b0;
        dwe_d = 1'b0;
        pre_d = 1'b0;
        iore_d = 1'b0;
        iowe_d = 1'b0;
        daddr_d = daddr_q;
        paddr_d = paddr_q;
        dwd_d = dwd_q;
        iowd_d = iowd_q;
        rfwe_d = 1'b0;
        rfpair_d = 1'b0;
        rfwa_d = rfwa_q;
        rfwd_d = rfwd_q;
        rfwdh_d = rfwdh_q;
        pwe_d = 1'b0;
        pws_d = pws_q;
        pwd_d = pwd_q;
        slp_d = 1'b0;
        wdt_d = 1'b0;
        brk_d = 1'b0;
        slpm_d = slpm_q;
        case (st_q)
            DTX_IDLE: begin
                if (issue) begin
                    op_d = op;
                    rd_d = rd;
                    rfwa_d = rd;
                    pws_d = ptr_sel;
                    base_d = base;
                    adj_d = adj;
                    pwd_d = newp;
                    case (op)
                        dtx_pkg::DTX_OP_NOP: done_d = 1'b1; // RULE15
                        dtx_pkg::DTX_OP_COPY_REGISTER: begin
                            rfwe_d = 1'b1; // RULE15
                            rfwd_d = rr_val;
                            done_d = 1'b1;
                        end
                        dtx_pkg::DTX_OP_COPY_REGISTER_PAIR: begin
                            rfwe_d = 1'b1; // RULE15
                            rfpair_d = 1'b1;
                            rfwd_d = rr_val;
                            rfwdh_d = rr_hi_val;
                            done_d = 1'b1;
                        end
                        dtx_pkg::DTX_OP_LOAD_IMMEDIATE: begin
                            rfwe_d = 1'b1; // RULE15
                            rfwd_d = imm8;
                            done_d = 1'b1;
                        end
                        dtx_pkg::DTX_OP_IO_IN: begin
                            rfwe_d = 1'b1; // RULE15
                            rfwd_d = io_rdata;
                            iore_d = 1'b1;
                            done_d = 1'b1;
                        end
                        dtx_pkg::DTX_OP_IO_OUT: begin
                            iowe_d = 1'b1; // RULE15
                            iowd_d = rr_val;
                            done_d = 1'b1;
                        end
                        dtx_pkg::DTX_OP_READ_VIA_POINTER,
                        dtx_pkg::DTX_OP_READ_POINTER_OFFSET: begin
                            dre_d = 1'b1; // RULE1 RULE2 RULE3
                            daddr_d = eff;
                            busy_d = 1'b1;
                            st_d = DTX_FINISH;
                        end
                        dtx_pkg::DTX_OP_READ_ABSOLUTE_ADDRESS: begin
                            dre_d = 1'b1; // RULE4
                            daddr_d = abs_addr;
                            busy_d = 1'b1;
                            st_d = DTX_FINISH;
                        end
                        dtx_pkg::DTX_OP_WRITE_VIA_POINTER,
                        dtx_pkg::DTX_OP_WRITE_POINTER_OFFSET: begin
                            dwe_d = 1'b1; // RULE5 RULE6 RULE7
                            daddr_d = eff;
                            dwd_d = rr_val;
                            busy_d = 1'b1;
                            st_d = DTX_FINISH;
                        end
                        dtx_pkg::DTX_OP_WRITE_ABSOLUTE_ADDRESS: begin
                            dwe_d = 1'b1; // RULE8
                            daddr_d = abs_addr;
                            dwd_d = rr_val;
                            busy_d = 1'b1;
                            st_d = DTX_FINISH;
                        end
                        dtx_pkg::DTX_OP_READ_PROGRAM_MEMORY: begin
                            pre_d = 1'b1; // RULE9
                            paddr_d = ptr_z;
                            pws_d = dtx_pkg::DTX_PTR_Z;
                            pwd_d = ptr_z + dtx_pkg::DTX_ONE16;
                            rd_d = use_r0 ? dtx_pkg::DTX_R0 : rd;
                            busy_d = 1'b1;
                            st_d = DTX_EXEC;
                        end
                        dtx_pkg::DTX_OP_PUSH: begin
                            dwe_d = 1'b1; // RULE10
                            daddr_d = sp_q;
                            dwd_d = rr_val;
                            sp_d = sp_q - dtx_pkg::DTX_ONE16;
                            busy_d = 1'b1;
                            st_d = DTX_FINISH;
                        end
                        dtx_pkg::DTX_OP_POP: begin
                            dre_d = 1'b1; // RULE11
                            daddr_d = sp_q + dtx_pkg::DTX_ONE16;
                            sp_d = sp_q + dtx_pkg::DTX_ONE16;
                            busy_d = 1'b1;
                            st_d = DTX_FINISH;
                        end
                        dtx_pkg::DTX_OP_SLEEP: begin
                            slp_d = sleep_enable; // RULE12
                            slpm_d = sleep_mode;
                            done_d = 1'b1;
                        end
                        dtx_pkg::DTX_OP_WATCHDOG_RESTART: begin
                            wdt_d = 1'b1; // RULE13
                            done_d = 1'b1;
                        end
                        dtx_pkg::DTX_OP_BREAK: brk_d = 1'b1; // RULE14
                        default: done_d = 1'b1;
                    endcase
                end
            end
            DTX_EXEC: begin
                st_d = DTX_FINISH; // RULE9
            end
            DTX_FINISH: begin
                busy_d = 1'b0;
                done_d = 1'b1;
                st_d = DTX_IDLE;
                case (op_q)
                    dtx_pkg::DTX_OP_READ_VIA_POINTER,
                    dtx_pkg::DTX_OP_READ_POINTER_OFFSET,
                    dtx_pkg::DTX_OP_READ_ABSOLUTE_ADDRESS,
                    dtx_pkg::DTX_OP_POP: begin
                        rfwe_d = 1'b1; // RULE1 RULE4 RULE11
                        rfwa_d = rd_q;
                        rfwd_d = dmem_rdata;
                        pwe_d = (op_q == dtx_pkg::DTX_OP_READ_VIA_POINTER) && (pwd_q != base_q);
                    end
                    dtx_pkg::DTX_OP_READ_PROGRAM_MEMORY: begin
                        rfwe_d = 1'b1; // RULE9
                        rfwa_d = rd_q;
                        rfwd_d = pmem_rdata;
                        pwe_d = adj_q == dtx_pkg::DTX_ADJ_POST_INC;
                    end
                    dtx_pkg::DTX_OP_WRITE_VIA_POINTER: pwe_d = pwd_q != base_q; // RULE5 RULE6
                    default: pwe_d = 1'b0; // RULE3 RULE7
                endcase
            end
            default: st_d = DTX_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_q <= DTX_IDLE;
            op_q <= dtx_pkg::DTX_OP_NOP;
            rd_q <= 5'h00;
            sp_q <= dtx_pkg::DTX_SP_RESET;
            base_q <= 16'h0000;
            adj_q <= dtx_pkg::DTX_ADJ_NONE;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            dre_q <= 1'b0;
            dwe_q <= 1'b0;
            pre_q <= 1'b0;
            iore_q <= 1'b0;
            iowe_q <= 1'b0;
            daddr_q <= 16'h0000;
            paddr_q <= 16'h0000;
            dwd_q <= 8'h00;
            iowd_q <= 8'h00;
            rfwe_q <= 1'b0;
            rfpair_q <= 1'b0;
            rfwa_q <= 5'h00;
            rfwd_q <= 8'h00;
            rfwdh_q <= 8'h00;
            pwe_q <= 1'b0;
            pws_q <= dtx_pkg::DTX_PTR_X;
            pwd_q <= 16'h0000;
            slp_q <= 1'b0;
            wdt_q <= 1'b0;
            brk_q <= 1'b0;
            slpm_q <= 3'h0;
        end else begin
            st_q <= st_d;
            op_q <= op_d;
            rd_q <= rd_d;
            sp_q <= sp_d;
            base_q <= base_d;
            adj_q <= adj_d;
            busy_q <= busy_d;
            done_q <= done_d;
            dre_q <= dre_d;
            dwe_q <= dwe_d;
            pre_q <= pre_d;
            iore_q <= iore_d;
            iowe_q <= iowe_d;
            daddr_q <= daddr_d;
            paddr_q <= paddr_d;
            dwd_q <= dwd_d;
            iowd_q <= iowd_d;
            rfwe_q <= rfwe_d;
            rfpair_q <= rfpair_d;
            rfwa_q <= rfwa_d;
            rfwd_q <= rfwd_d;
            rfwdh_q <= rfwdh_d;
            pwe_q <= pwe_d;
            pws_q <= pws_d;
            pwd_q <= pwd_d;
            slp_q <= slp_d;
            wdt_q <= wdt_d;
            brk_q <= brk_d;
            slpm_q <= slpm_d;
        end
    end

    assign busy = busy_q;
    assign done = done_q;
    assign dmem_re = dre_q;
    assign dmem_we = dwe_q;
    assign dmem_addr = daddr_q;
    assign dmem_wdata = dwd_q;
    assign pmem_re = pre_q;
    assign pmem_addr = paddr_q;
    assign io_re = iore_q;
    assign io_we = iowe_q;
    assign io_wdata = iowd_q;
    assign rf_we = rfwe_q;
    assign rf_we_pair = rfpair_q;
    assign rf_waddr = rfwa_q;
    assign rf_wdata = rfwd_q;
    assign rf_wdata_hi = rfwdh_q;
    assign ptr_we = pwe_q;
    assign ptr_wsel = pws_q;
    assign ptr_wdata = pwd_q;
    assign sp = sp_q;
    assign flags_we = 1'b0; // RULE15
    assign sleep_req = slp_q;
    assign sleep_mode_out = slpm_q;
    assign wdt_restart = wdt_q;
    assign debug_break = brk_q;

    property p_two_cycle_load;
        @(posedge clk) disable iff (!rst_b)
        (st_q == DTX_IDLE && issue && op == dtx_pkg::DTX_OP_READ_VIA_POINTER) |-> ##2 (done && rf_we);
    endproperty
    a_two_cycle_load: assert property (p_two_cycle_load) else $error("load not two cycles"); // RULE1

    property p_predec_addr;
        @(posedge clk) disable iff (!rst_b)
        (st_q == DTX_IDLE && issue && op == dtx_pkg::DTX_OP_READ_VIA_POINTER &&
         adj == dtx_pkg::DTX_ADJ_PRE_DEC) |=> (dmem_addr == $past(base) - dtx_pkg::DTX_ONE16);
    endproperty
    a_predec_addr: assert property (p_predec_addr) else $error("pre-decrement address wrong"); // RULE2

    property p_offset_keeps_ptr;
        @(posedge clk) disable iff (!rst_b)
        (st_q == DTX_IDLE && issue && op == dtx_pkg::DTX_OP_READ_POINTER_OFFSET) |-> ##2 !ptr_we;
    endproperty
    a_offset_keeps_ptr: assert property (p_offset_keeps_ptr) else $error("offset load moved ptr"); // RULE3

    property p_abs_store;
        @(posedge clk) disable iff (!rst_b)
        (st_q == DTX_IDLE && issue && op == dtx_pkg::DTX_OP_WRITE_ABSOLUTE_ADDRESS)
        |=> (dmem_we && dmem_addr == $past(abs_addr)) ##1 done;
    endproperty
    a_abs_store: assert property (p_abs_store) else $error("absolute store wrong"); // RULE8

    property p_pmem_three;
        @(posedge clk) disable iff (!rst_b)
        (st_q == DTX_IDLE && issue && op == dtx_pkg::DTX_OP_READ_PROGRAM_MEMORY)
        |-> ##1 !done ##1 !done ##1 (done && rf_we);
    endproperty
    a_pmem_three: assert property (p_pmem_three) else $error("program read not three cycles"); // RULE9

    property p_push_sp;
        @(posedge clk) disable iff (!rst_b)
        (st_q == DTX_IDLE && issue && op == dtx_pkg::DTX_OP_PUSH) |=> (sp == $past(sp) - 16'h0001);
    endproperty
    a_push_sp: assert property (p_push_sp) else $error("push did not move stack"); // RULE10

    property p_wdr_one;
        @(posedge clk) disable iff (!rst_b)
        (st_q == DTX_IDLE && issue && op == dtx_pkg::DTX_OP_WATCHDOG_RESTART) |=> (wdt_restart && done);
    endproperty
    a_wdr_one: assert property (p_wdr_one) else $error("watchdog restart late"); // RULE13

    property p_no_flags;
        @(posedge clk) disable iff (!rst_b)
        done |-> !flags_we;
    endproperty
    a_no_flags: assert property (p_no_flags) else $error("flags written"); // RULE15
endmodule : dtx_exec
`default_nettype wire

// >>> tb/dtx_mem_model.sv
// data sram and program flash model facing the transfer executor
`timescale 1ns/1ps
`default_nettype none
module dtx_mem_model (
    input wire logic clk,
    input wire logic dmem_re,
    input wire logic dmem_we,
    input wire logic [15:0] dmem_addr,
    input wire logic [7:0] dmem_wdata,
    output logic [7:0] dmem_rdata,
    input wire logic pmem_re,
    input wire logic [15:0] pmem_addr,
    output logic [7:0] pmem_rdata
);
    logic [7:0] mem [0:1023];
    initial begin
        for (int i = 0; i < 1024; i++) begin
            mem[i] = i[7:0] ^ 8'h5a;
        end
        pmem_rdata = 8'h00;
    end
    // sram answers in the strobe's own cycle, inverted otherwise; flash holds its byte
    assign dmem_rdata = (dmem_re === 1'b1) ? mem[dmem_addr[9:0]] : ~mem[dmem_addr[9:0]];
    always @(posedge clk) begin
        if (dmem_we === 1'b1) begin
            mem[dmem_addr[9:0]] <= dmem_wdata;
        end
        if (pmem_re === 1'b1) begin
            pmem_rdata <= pmem_addr[7:0] ^ 8'ha5;
        end
    end
endmodule : dtx_mem_model
`default_nettype wire

// >>> tb/dtx_exec_tb.sv
// testbench: table-driven checks of the transfer executor
`timescale 1ns/1ps
`default_nettype none
module dtx_exec_tb;
    typedef struct {
        dtx_pkg::dtx_op_t op;
        logic [1:0] sel;
        logic [1:0] adj;
        logic [4:0] rd;
        logic [7:0] rr;
        logic [15:0] imm;
        int cyc;
        logic [11:0] ev;
        logic [15:0] a;
        logic [7:0] d;
    } dtx_row_t;
    logic clk = 1'b0, rst_b = 1'b0, issue = 1'b0, use_r0 = 1'b0, sleep_enable = 1'b1;
    dtx_pkg::dtx_op_t op = dtx_pkg::DTX_OP_NOP;
    dtx_pkg::dtx_ptr_t ptr_sel = dtx_pkg::DTX_PTR_X;
    dtx_pkg::dtx_adj_t adj = dtx_pkg::DTX_ADJ_NONE;
    logic [4:0] rd = 5'h00;
    logic [7:0] rr_val = 8'h00, rr_hi_val = 8'h00, imm8 = 8'h00, io_rdata = 8'h00;
    logic [5:0] disp = 6'h00;
    logic [2:0] sleep_mode = 3'h0;
    logic [15:0] abs_addr = 16'h0000, ptr_x = 16'h0110, ptr_y = 16'h0120, ptr_z = 16'h0130;
    logic [7:0] dmem_rdata, pmem_rdata, dmem_wdata, io_wdata, rf_wdata, rf_wdata_hi;
    logic busy, done, dmem_re, dmem_we, pmem_re, io_re, io_we, rf_we, rf_we_pair, ptr_we;
    logic flags_we, sleep_req, wdt_restart, debug_break;
    logic [15:0] dmem_addr, pmem_addr, ptr_wdata, sp;
    logic [4:0] rf_waddr;
    logic [2:0] sleep_mode_out;
    dtx_pkg::dtx_ptr_t ptr_wsel;
    logic [15:0] esp = 16'h01ff;
    int mismatches = 0;
    int checked = 0;
    dtx_row_t rows [26] = '{
    '{dtx_pkg::DTX_OP_READ_VIA_POINTER,2'h0,2'h0,5'h01,8'h00,16'h0000,2,12'h021,16'h0110,8'h4a},
    '{dtx_pkg::DTX_OP_READ_VIA_POINTER,2'h0,2'h1,5'h02,8'h00,16'h0000,2,12'h0a1,16'h0110,8'h4a},
    '{dtx_pkg::DTX_OP_READ_VIA_POINTER,2'h0,2'h2,5'h03,8'h00,16'h0000,2,12'h0a1,16'h010f,8'h55},
    '{dtx_pkg::DTX_OP_READ_VIA_POINTER,2'h1,2'h1,5'h04,8'h00,16'h0000,2,12'h0a1,16'h0120,8'h7a},
    '{dtx_pkg::DTX_OP_READ_VIA_POINTER,2'h2,2'h2,5'h05,8'h00,16'h0000,2,12'h0a1,16'h012f,8'h75},
    '{dtx_pkg::DTX_OP_READ_POINTER_OFFSET,2'h1,2'h0,5'h06,8'h00,16'h003f,2,12'h021,16'h015f,8'h05},
    '{dtx_pkg::DTX_OP_READ_POINTER_OFFSET,2'h2,2'h0,5'h07,8'h00,16'h0005,2,12'h021,16'h0135,8'h6f},
    '{dtx_pkg::DTX_OP_READ_ABSOLUTE_ADDRESS,2'h0,2'h0,5'h08,8'h00,16'h0200,2,
        12'h021,16'h0200,8'h5a},
    '{dtx_pkg::DTX_OP_WRITE_VIA_POINTER,2'h0,2'h0,5'h01,8'h11,16'h0000,2,12'h002,16'h0110,8'h11},
    '{dtx_pkg::DTX_OP_WRITE_VIA_POINTER,2'h1,2'h1,5'h01,8'h22,16'h0000,2,12'h082,16'h0120,8'h22},
    '{dtx_pkg::DTX_OP_WRITE_VIA_POINTER,2'h2,2'h2,5'h01,8'h33,16'h0000,2,12'h082,16'h012f,8'h33},
    '{dtx_pkg::DTX_OP_WRITE_POINTER_OFFSET,2'h1,2'h0,5'h01,8'h44,16'h0010,2,
        12'h002,16'h0130,8'h44},
    '{dtx_pkg::DTX_OP_WRITE_ABSOLUTE_ADDRESS,2'h0,2'h0,5'h01,8'h55,16'h0210,2,
        12'h002,16'h0210,8'h55},
    '{dtx_pkg::DTX_OP_READ_VIA_POINTER,2'h0,2'h0,5'h09,8'h00,16'h0000,2,12'h021,16'h0110,8'h11},
    '{dtx_pkg::DTX_OP_READ_PROGRAM_MEMORY,2'h2,2'h0,5'h00,8'h00,16'h0000,3,
        12'h024,16'h0130,8'h95},
    '{dtx_pkg::DTX_OP_READ_PROGRAM_MEMORY,2'h2,2'h1,5'h0a,8'h00,16'h0000,3,
        12'h0a4,16'h0130,8'h95},
    '{dtx_pkg::DTX_OP_PUSH,2'h0,2'h0,5'h01,8'h66,16'h0000,2,12'h002,16'h01ff,8'h66},
    '{dtx_pkg::DTX_OP_POP,2'h0,2'h0,5'h0b,8'h00,16'h0000,2,12'h021,16'h01ff,8'h66},
    '{dtx_pkg::DTX_OP_COPY_REGISTER,2'h0,2'h0,5'h0c,8'h77,16'h0000,1,12'h020,16'h0000,8'h77},
    '{dtx_pkg::DTX_OP_COPY_REGISTER_PAIR,2'h0,2'h0,5'h0e,8'h12,16'h0000,1,12'h060,16'h0000,8'h12},
    '{dtx_pkg::DTX_OP_LOAD_IMMEDIATE,2'h0,2'h0,5'h0f,8'h9c,16'h0000,1,12'h020,16'h0000,8'h9c},
    '{dtx_pkg::DTX_OP_IO_IN,2'h0,2'h0,5'h10,8'h3c,16'h0000,1,12'h028,16'h0000,8'hc3},
    '{dtx_pkg::DTX_OP_IO_OUT,2'h0,2'h0,5'h01,8'h5e,16'h0000,1,12'h010,16'h0000,8'h5e},
    '{dtx_pkg::DTX_OP_NOP,2'h0,2'h0,5'h01,8'h00,16'h0000,1,12'h000,16'h0000,8'h00},
    '{dtx_pkg::DTX_OP_SLEEP,2'h0,2'h0,5'h05,8'h00,16'h0000,1,12'h100,16'h0000,8'h00},
    '{dtx_pkg::DTX_OP_WATCHDOG_RESTART,2'h0,2'h0,5'h01,8'h00,16'h0000,1,12'h200,16'h0000,8'h00}};
    dtx_row_t s;
    int nrf;
    int nd;
    int nb;

    dtx_exec i_dtx_exec (.clk, .rst_b, .issue, .op, .ptr_sel, .adj, .rd, .rr_val, .rr_hi_val,
        .imm8, .disp, .abs_addr, .use_r0, .ptr_x, .ptr_y, .ptr_z, .dmem_rdata, .pmem_rdata,
        .io_rdata, .sleep_mode, .sleep_enable, .busy, .done, .dmem_re, .dmem_we, .dmem_addr,
        .dmem_wdata, .pmem_re, .pmem_addr, .io_re, .io_we, .io_wdata, .rf_we, .rf_we_pair,
        .rf_waddr, .rf_wdata, .rf_wdata_hi, .ptr_we, .ptr_wsel, .ptr_wdata, .sp, .flags_we,
        .sleep_req, .sleep_mode_out, .wdt_restart, .debug_break);
    dtx_mem_model i_dtx_mem_model (.clk, .dmem_re, .dmem_we, .dmem_addr, .dmem_wdata,
        .dmem_rdata, .pmem_re, .pmem_addr, .pmem_rdata);

    always #25 clk = ~clk;

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", nm, e, g);
            mismatches++;
        end
    endtask : chk

    task automatic set(input dtx_row_t r);
        op = r.op;
        ptr_sel = dtx_pkg::dtx_ptr_t'(r.sel);
        adj = dtx_pkg::dtx_adj_t'(r.adj);
        rd = (r.op == dtx_pkg::DTX_OP_READ_PROGRAM_MEMORY && r.rd == 5'h00) ? 5'h1f : r.rd;
        rr_val = r.rr;
        rr_hi_val = ~r.rr;
        imm8 = r.rr;
        io_rdata = ~r.rr;
        disp = r.imm[5:0];
        abs_addr = r.imm;
        use_r0 = (r.op == dtx_pkg::DTX_OP_READ_PROGRAM_MEMORY) && (r.rd == 5'h00);
        sleep_mode = r.rd[2:0];
    endtask : set

    task automatic run(input dtx_row_t r);
        logic [11:0] ev;
        logic [15:0] a;
        logic [15:0] p;
        logic [15:0] base;
        logic [7:0] d;
        logic [7:0] hi;
        logic [4:0] wa;
        logic bz;
        int n;
        ev = 12'h000;
        base = (r.sel == 2'h0) ? ptr_x : (r.sel == 2'h1) ? ptr_y : ptr_z;
        @(posedge clk);
        #1;
        set(r);
        issue = 1'b1;
        @(posedge clk);
        #1;
        issue = 1'b0;
        for (n = 1; n < 6; n++) begin
            ev = ev | {flags_we, debug_break, wdt_restart, sleep_req, ptr_we, rf_we_pair,
                rf_we, io_we, io_re, pmem_re, dmem_we, dmem_re};
            if (dmem_re === 1'b1 || dmem_we === 1'b1) a = dmem_addr;
            if (pmem_re === 1'b1) a = pmem_addr;
            if (rf_we === 1'b1) d = rf_wdata;
            if (rf_we === 1'b1) hi = rf_wdata_hi;
            if (rf_we === 1'b1) wa = rf_waddr;
            if (dmem_we === 1'b1) d = dmem_wdata;
            if (io_we === 1'b1) d = io_wdata;
            if (ptr_we === 1'b1) p = ptr_wdata;
            if (n == 1) bz = busy;
            if (done === 1'b1) break;
            @(posedge clk);
            #1;
        end
        if (r.op == dtx_pkg::DTX_OP_PUSH) esp = esp - 16'h0001;
        if (r.op == dtx_pkg::DTX_OP_POP) esp = esp + 16'h0001;
        chk("cycles", r.cyc, n);
        chk("busy", (r.cyc > 1) ? 16'h0001 : 16'h0000, bz);
        chk("strobes", r.ev, ev);
        if (r.ev[2:0] != 3'h0) chk("address", r.a, a);
        if (r.ev[1] || r.ev[4] || r.ev[5]) chk("data", r.d, d);
        if (r.ev[5]) chk("dest", r.rd, wa);
        if (r.ev[6]) chk("high", 8'(~r.rr), hi);
        if (r.ev[7]) chk("pointer", (r.adj == 2'h1) ? base + 16'h1 : base - 16'h1, p);
        if (r.ev[7]) chk("ptr_sel", r.sel, ptr_wsel);
        if (r.ev[8]) chk("mode", r.rd[2:0], sleep_mode_out);
        chk("sp", esp, sp);
    endtask : run

    task automatic pulses(input dtx_row_t r, input int drop);
        @(posedge clk);
        #1;
        set(r);
        issue = 1'b1;
        nrf = 0;
        nd = 0;
        nb = 0;
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            #1;
            if (i == drop) issue = 1'b0;
            nrf += (rf_we === 1'b1);
            nd += (done === 1'b1);
            nb += (debug_break === 1'b1);
        end
    endtask : pulses

    task test_done;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done

    initial begin
        #100000;
        mismatches++;
        test_done();
    end

    initial begin
        repeat (2) @(posedge clk);
        #1;
        rst_b = 1'b1;
        chk("sp", 16'h01ff, sp);
        chk("busy", 16'h0000, busy);
        foreach (rows[i]) run(rows[i]);
        s = rows[24];
        s.ev = 12'h000;
        sleep_enable = 1'b0;
        run(s);
        pulses(rows[7], 1);
        chk("loads", 16'h0001, nrf);
        chk("done", 16'h0001, nd);
        run(rows[16]);
        s.op = dtx_pkg::DTX_OP_BREAK;
        pulses(s, 0);
        chk("break", 16'h0001, nb);
        chk("break done", 16'h0000, nd);
        rst_b = 1'b0;
        @(posedge clk);
        #1;
        rst_b = 1'b1;
        chk("sp", 16'h01ff, sp);
        chk("busy", 16'h0000, busy);
        test_done();
    end
endmodule : dtx_exec_tb
`default_nettype wire
